//--- rtl/ascc_pkg.sv
// Purpose: Shared constants and types of the serial channel block.
// Assumes: 8-bit I/O register port, one system clock.
// Notes:   Register offsets, single-bit field positions, source reset value and clock counts live here.
`default_nettype none
package ascc_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ASCC_OFS_A0   = 8'h00;
  localparam logic [7:0] ASCC_OFS_A1   = 8'h01;
  localparam logic [7:0] ASCC_OFS_B0   = 8'h02;
  localparam logic [7:0] ASCC_OFS_B1   = 8'h03;
  localparam logic [7:0] ASCC_OFS_ST0  = 8'h04;
  localparam logic [7:0] ASCC_OFS_ST1  = 8'h05;
  localparam logic [7:0] ASCC_OFS_TD0  = 8'h06;
  localparam logic [7:0] ASCC_OFS_TD1  = 8'h07;
  localparam logic [7:0] ASCC_OFS_RD0  = 8'h08;
  localparam logic [7:0] ASCC_OFS_RD1  = 8'h09;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ASCC_A_FILTER = 7;
  localparam int ASCC_A_RX_ON  = 6;
  localparam int ASCC_A_TX_ON  = 5;
  localparam int ASCC_A_BIT4   = 4;
  localparam int ASCC_A_ERRCLR = 3;
  localparam int ASCC_B_MPSEND = 7;
  localparam int ASCC_B_MPFMT  = 6;
  localparam int ASCC_B_PRESC  = 5;
  localparam int ASCC_B_ODD    = 4;
  localparam int ASCC_B_DIV    = 3;
  // ----------------------------------------------------------------
  // Reset values, timing counts and queue sizes
  // ----------------------------------------------------------------
  localparam logic [2:0]  ASCC_SS_EXT    = 3'h7;
  localparam logic [2:0]  ASCC_SS_RST    = 3'h7;
  localparam logic [10:0] ASCC_PRESC_LO  = 11'h00a;
  localparam logic [10:0] ASCC_PRESC_HI  = 11'h01e;
  localparam logic [6:0]  ASCC_RATIO_LO  = 7'h10;
  localparam logic [6:0]  ASCC_RATIO_HI  = 7'h40;
  localparam logic [6:0]  ASCC_RATIO_ONE = 7'h01;
  localparam int          ASCC_TXQ_W     = 8;
  localparam int          ASCC_TXQ_D     = 8;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic len8;
    logic par_on;
    logic stop2;
  } ascc_fmt_t;
  typedef struct packed {
    logic overrun;
    logic parity;
    logic framing;
    logic break_flag;
  } ascc_err_t;
  typedef enum logic {ASCC_TX_IDLE, ASCC_TX_SHIFT} ascc_tx_t;
  typedef enum logic [1:0] {
    ASCC_RX_IDLE, ASCC_RX_START, ASCC_RX_BITS
  } ascc_rx_t;
endpackage : ascc_pkg
`default_nettype wire

//--- rtl/ascc_top.sv
// Purpose: Two asynchronous serial channels with control registers.
// Assumes: Pin inputs are synchronous to clock; reset is synchronous.
// Notes:   Read data is registered one cycle after the read strobe.
`default_nettype none
// ------------------------------------------------------------------
// Transmit queue
// ------------------------------------------------------------------
module ascc_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic         clock,
  input  wire logic         reset_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0]   cnt;
  logic          push;
  logic          pop;
  // Pointers wrap naturally, so depth must be a power of two.
  assign in_ready  = cnt != (AW+1)'(D);
  assign out_valid = cnt != '0;
  assign out_data  = mem[rp];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  // Storage has no reset; only valid entries are ever read.
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wp] <= in_data;
    end
  end
  // Pointer and fill level update.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      wp  <= '0;
      rp  <= '0;
      cnt <= '0;
    end else begin
      if (push) wp <= wp + AW'(1);
      if (pop) rp <= rp + AW'(1);
      cnt <= cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : ascc_fifo

// ------------------------------------------------------------------
// One channel
// ------------------------------------------------------------------
// Functional notes
// - Wake-up filter passes only flagged characters to flags; clears on reset.
// - Filter off means every character counts; ignored outside multiproc.
// - Dropping transmitter enable aborts the character; holding-empty kept.
// - Both enables forced low by reset and by peripheral halt.
// - Channel 0 control A bit 4 drives request-to-send pin directly.
// - Channel 1 control A bit 4 picks DMA-end or clock pin; resets 0.
// - Control A bit 3 reads the last received multiproc flag bit.
// - Writing control A bit 3 as zero clears all error flags.
// - Format bits set data length, parity enable and stop count.
// - Frame is start, data, optional parity, then stop bits.
// - Transmitter sends control B bit 7 as multiproc flag bit.
// - Multiproc frame: start, data, flag bit, stops, never parity.
// - Control B bit 5 reads clear-to-send; high holds holding-empty low.
// - Channel 1 clear-to-send read valid only when pin selects it.
// - Prescale bit written when source not external and baud generator mode low: 0 is 10, 1 is 30.
// - Control B bit 4 picks even or odd parity only.
// - Control B bit 3 picks sample ratio 16 or 64.
// - Source 111, the reset value, uses the external clock pin.
// - Other source codes divide the prescaled system clock by two to the code.
// - A loaded character sets data-available even when in error.
module ascc_chan #(
  parameter bit CH1 = 1'b0
) (
  input  wire logic       clock,
  input  wire logic       reset_n,
  input  wire logic       io_write,
  input  wire logic       io_read,
  input  wire logic [7:0] io_wdata,
  input  wire logic       sel_a,
  input  wire logic       sel_b,
  input  wire logic       sel_stat,
  input  wire logic       sel_tdr,
  input  wire logic       sel_rdr,
  output logic [7:0]      rd_value,
  input  wire logic       halt,
  input  wire logic       unity,
  input  wire logic       bgm,
  input  wire logic       ext_clk,
  input  wire logic       cts_n,
  input  wire logic       rxd,
  output logic            txd,
  output logic            bit4
);
  logic             filter;
  logic             rx_on;
  logic             tx_on;
  ascc_pkg::ascc_fmt_t fmt;
  logic             mp_send;
  logic             mp_fmt;
  logic             presc;
  logic             odd;
  logic             div;
  logic [2:0]       ss;
  logic             wr_a;
  logic             wr_b;
  logic             err_clr;
  logic             rdr_read;
  assign wr_a     = io_write & sel_a;
  assign wr_b     = io_write & sel_b;
  assign rdr_read = io_read & sel_rdr;
  assign err_clr  = wr_a & ~io_wdata[ascc_pkg::ASCC_A_ERRCLR];

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // enables forced off
  always_ff @(posedge clock) begin
    if (!reset_n || halt) begin
      rx_on <= 1'h0;
      tx_on <= 1'h0;
    end else if (wr_a) begin
      rx_on <= io_wdata[ascc_pkg::ASCC_A_RX_ON];
      tx_on <= io_wdata[ascc_pkg::ASCC_A_TX_ON];
    end
  end
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      filter <= 1'h0;
      bit4   <= 1'h0;
      fmt    <= '0;
    end else if (wr_a) begin
      filter <= io_wdata[ascc_pkg::ASCC_A_FILTER];
      bit4   <= io_wdata[ascc_pkg::ASCC_A_BIT4];
      fmt    <= io_wdata[2:0];
    end
  end
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      mp_send <= 1'h0;
      mp_fmt  <= 1'h0;
      presc   <= 1'h0;
      odd     <= 1'h0;
      div     <= 1'h0;
      ss      <= ascc_pkg::ASCC_SS_RST;
    end else if (wr_b) begin
      mp_send <= io_wdata[ascc_pkg::ASCC_B_MPSEND];
      mp_fmt  <= io_wdata[ascc_pkg::ASCC_B_MPFMT];
      odd     <= io_wdata[ascc_pkg::ASCC_B_ODD];
      div     <= io_wdata[ascc_pkg::ASCC_B_DIV];
      ss      <= io_wdata[2:0];
      if (io_wdata[2:0] != ascc_pkg::ASCC_SS_EXT && !bgm) begin
        presc <= io_wdata[ascc_pkg::ASCC_B_PRESC];
      end
    end
  end

  // ----------------------------------------------------------------
  // Sample clock
  // ----------------------------------------------------------------
  logic [10:0] div_cnt;
  logic [10:0] period;
  logic        ext_q;
  logic        tick;
  logic [6:0]  ratio;
  logic [6:0]  ratio_m1;
  logic [6:0]  half_m1;
  assign period = (presc ? ascc_pkg::ASCC_PRESC_HI
                         : ascc_pkg::ASCC_PRESC_LO) << ss;
  assign ratio = unity ? ascc_pkg::ASCC_RATIO_ONE
               : (div ? ascc_pkg::ASCC_RATIO_HI
                      : ascc_pkg::ASCC_RATIO_LO);
  assign ratio_m1 = ratio - 7'h01;
  assign half_m1  = (ratio >> 1) - 7'h01;
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      div_cnt <= '0;
      ext_q   <= 1'h0;
      tick    <= 1'h0;
    end else begin
      ext_q <= ext_clk;
      if (ss == ascc_pkg::ASCC_SS_EXT) begin
        div_cnt <= '0;
        tick    <= ext_clk & ~ext_q;
      end else if (div_cnt >= period - 11'h001) begin
        div_cnt <= '0;
        tick    <= 1'h1;
      end else begin
        div_cnt <= div_cnt + 11'h001;
        tick    <= 1'h0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  // frame assembly
  function automatic logic [15:0] ascc_frame(
    input ascc_pkg::ascc_fmt_t f,
    input logic                mp,
    input logic                multiproc_flag_bit,
    input logic                odd_p,
    input logic [7:0]          d
  );
    logic [11:0] v;
    logic        p;
    int          n;
    v    = '1;
    v[0] = 1'h0;
    p    = odd_p;
    n    = 1;
    for (int i = 0; i < 8; i++) begin
      if (i < 7 || f.len8) begin
        v[n] = d[i];
        p    = p ^ d[i];
        n++;
      end
    end
    if (mp) begin
      v[n] = multiproc_flag_bit;
      n++;
    end else if (f.par_on) begin
      v[n] = p;
      n++;
    end
    n = n + (f.stop2 ? 2 : 1);
    return {n[3:0], v};
  endfunction : ascc_frame

  ascc_pkg::ascc_tx_t tx_state;
  logic [11:0] tx_shift;
  logic [3:0]  tx_left;
  logic [6:0]  tx_sub;
  logic        q_valid;
  logic        q_ready;
  logic [7:0]  q_data;
  logic        tx_start;
  logic        tx_holding_empty;
  logic        tx_holding_empty_raw;
  // A frame starts on a tick, so the start bit lasts a whole bit time
  // even in unity clock mode.
  assign tx_start = tx_state == ascc_pkg::ASCC_TX_IDLE
                  & tx_on & q_valid & tick;
  assign q_ready  = tx_start;

  // Software learns of back-pressure through holding-empty.
  ascc_fifo #(
    .W (ascc_pkg::ASCC_TXQ_W),
    .D (ascc_pkg::ASCC_TXQ_D)
  ) u_txq (
    .clock     (clock),
    .reset_n   (reset_n),
    .in_valid  (io_write & sel_tdr),
    .in_ready  (tx_holding_empty_raw),
    .in_data   (io_wdata),
    .out_valid (q_valid),
    .out_ready (q_ready),
    .out_data  (q_data)
  );
  assign tx_holding_empty = tx_holding_empty_raw & ~cts_n;

  always_ff @(posedge clock) begin
    if (!reset_n || !tx_on) begin
      tx_state <= ascc_pkg::ASCC_TX_IDLE;
      tx_shift <= '1;
      tx_left  <= '0;
      tx_sub   <= '0;
    end else if (tx_start) begin
      {tx_left, tx_shift} <= ascc_frame(fmt, mp_fmt, mp_send,
                                        odd, q_data);
      tx_sub   <= '0;
      tx_state <= ascc_pkg::ASCC_TX_SHIFT;
    end else if (tx_state == ascc_pkg::ASCC_TX_SHIFT && tick) begin
      if (tx_sub == ratio_m1) begin
        tx_sub   <= '0;
        tx_shift <= {1'h1, tx_shift[11:1]};
        tx_left  <= tx_left - 4'h1;
        if (tx_left == 4'h1) tx_state <= ascc_pkg::ASCC_TX_IDLE;
      end else begin
        tx_sub <= tx_sub + 7'h01;
      end
    end
  end
  // Line idles high whenever nothing is being shifted.
  always_ff @(posedge clock) begin
    if (!reset_n || !tx_on) begin
      txd <= 1'h1;
    end else begin
      txd <= (tx_state == ascc_pkg::ASCC_TX_SHIFT) ? tx_shift[0]
                                                  : 1'h1;
    end
  end

  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------
  ascc_pkg::ascc_rx_t rx_state;
  ascc_pkg::ascc_err_t err;
  logic [6:0] rx_sub;
  logic [3:0] rx_idx;
  logic [3:0] rx_last;
  logic [9:0] rx_bits;
  logic       rx_done;
  logic [7:0] rx_data;
  logic       rx_extra;
  logic       accept;
  logic       load;
  logic [7:0] rdr;
  logic       avail;
  logic       last_mp;
  // Stop sample index; only the first stop bit is checked.
  assign rx_last = (fmt.len8 ? 4'h8 : 4'h7)
                 + ((mp_fmt || fmt.par_on) ? 4'h1 : 4'h0);
  assign rx_done  = rx_state == ascc_pkg::ASCC_RX_BITS & tick
                  & rx_sub == ratio_m1 & rx_idx == rx_last;
  assign rx_data  = fmt.len8 ? rx_bits[7:0] : {1'h0, rx_bits[6:0]};
  assign rx_extra = fmt.len8 ? rx_bits[8] : rx_bits[7];
  assign accept   = ~(mp_fmt & filter & ~rx_extra);
  assign load     = rx_done & accept & (~avail | rdr_read);

  // Outside unity mode the start edge is rechecked at mid bit to reject glitches.
  always_ff @(posedge clock) begin
    if (!reset_n || !rx_on) begin
      rx_state <= ascc_pkg::ASCC_RX_IDLE;
      rx_sub   <= '0;
      rx_idx   <= '0;
      rx_bits  <= '0;
    end else if (tick) begin
      unique case (rx_state)
        ascc_pkg::ASCC_RX_IDLE: begin
          rx_sub <= '0;
          rx_idx <= '0;
          if (!rxd) begin
            rx_state <= (ratio == ascc_pkg::ASCC_RATIO_ONE)
                      ? ascc_pkg::ASCC_RX_BITS
                      : ascc_pkg::ASCC_RX_START;
          end
        end
        ascc_pkg::ASCC_RX_START: begin
          if (rx_sub == half_m1) begin
            rx_sub   <= '0;
            rx_state <= rxd ? ascc_pkg::ASCC_RX_IDLE
                            : ascc_pkg::ASCC_RX_BITS;
          end else begin
            rx_sub <= rx_sub + 7'h01;
          end
        end
        ascc_pkg::ASCC_RX_BITS: begin
          if (rx_sub == ratio_m1) begin
            rx_sub          <= '0;
            rx_bits[rx_idx] <= rxd;
            if (rx_idx == rx_last) begin
              rx_state <= ascc_pkg::ASCC_RX_IDLE;
            end else begin
              rx_idx <= rx_idx + 4'h1;
            end
          end else begin
            rx_sub <= rx_sub + 7'h01;
          end
        end
        default: rx_state <= ascc_pkg::ASCC_RX_IDLE;
      endcase
    end
  end
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      avail <= 1'h0;
      rdr   <= '0;
    end else if (load) begin
      avail <= 1'h1;
      rdr   <= rx_data;
    end else if (rdr_read) begin
      avail <= 1'h0;
    end
  end
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      err <= '0;
    end else begin
      err <= (err_clr ? '0 : err) | {
        rx_done & accept & avail & ~rdr_read,
        load & fmt.par_on & ~mp_fmt & (^rx_data ^ odd ^ rx_extra),
        load & ~rxd,
        load & ~rxd & (rx_data == 8'h00)};
    end
  end
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      last_mp <= 1'h0;
    end else if (rx_done && mp_fmt) begin
      last_mp <= rx_extra;
    end
  end

  // ----------------------------------------------------------------
  // Read multiplexer
  // ----------------------------------------------------------------
  // clear-to-send read raw
  always_comb begin
    rd_value = 8'h00;
    if (sel_a) begin
      rd_value = {filter, rx_on, tx_on, bit4, last_mp, fmt};
    end else if (sel_b) begin
      rd_value = {mp_send, mp_fmt, cts_n, odd, div, ss};
    end else if (sel_stat) begin
      rd_value = {avail, err.overrun, err.parity, err.framing,
                  err.break_flag, 1'h0, tx_holding_empty, 1'h0};
    end else if (sel_rdr) begin
      rd_value = rdr;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking ascc_cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  enables_halt_a: assert property (halt |=> !rx_on && !tx_on)
    else $error("Enables not forced off by halt.");
  cts_empty_a: assert property (cts_n |-> !tx_holding_empty)
    else $error("Holding-empty high while clear-to-send high.");
  err_clear_a: assert property (err_clr && !rx_done |=> err == '0)
    else $error("Error flags not cleared.");
  src_reset_a: assert property (disable iff (1'b0)
    !reset_n |=> ss == ascc_pkg::ASCC_SS_EXT)
    else $error("Source select not external after reset.");
  filter_drop_a: assert property (rx_done && mp_fmt && filter
    && !rx_extra && !avail |=> !avail)
    else $error("Filtered character set data-available.");
  avail_load_a: assert property (rx_done && accept && !avail
    |=> avail && rdr == $past(rx_data))
    else $error("Received character not loaded.");
  tx_abort_a: assert property (!tx_on |=> txd)
    else $error("Line not idle after transmitter off.");
  start_bit_a: assert property (tx_start ##1 tx_on |=> !txd)
    else $error("Start bit missing.");
  presc_write_a: assert property (wr_b && !bgm
    && io_wdata[2:0] != ascc_pkg::ASCC_SS_EXT
    |=> presc == $past(io_wdata[ascc_pkg::ASCC_B_PRESC]))
    else $error("Prescale not written.");
  presc_hold_a: assert property (wr_b && (bgm
    || io_wdata[2:0] == ascc_pkg::ASCC_SS_EXT) |=> $stable(presc))
    else $error("Prescale changed while its write is blocked.");
  rx_char_c: cover property (load);
  overrun_c: cover property ($rose(err.overrun));
  tx_frame_c: cover property (tx_start ##[1:400] !tx_on);
  ext_tick_c: cover property (ss == ascc_pkg::ASCC_SS_EXT && tick);
endmodule : ascc_chan

// ------------------------------------------------------------------
// Top level
// ------------------------------------------------------------------
module ascc_top (
  input  wire logic       clock,
  input  wire logic       reset_n,
  input  wire logic [7:0] io_addr,
  input  wire logic [7:0] io_wdata,
  input  wire logic       io_write,
  input  wire logic       io_read,
  output logic [7:0]      io_rdata,
  input  wire logic       peripheral_halt,
  input  wire logic [1:0] unity_clock_mode,
  input  wire logic [1:0] baud_generator_mode,
  input  wire logic [1:0] serial_clock_pin,
  input  wire logic [1:0] clear_to_send_n,
  input  wire logic [1:0] rx_line,
  output logic [1:0]      tx_line,
  output logic            request_to_send_out,
  output logic            clk_pin1_alt_select
);
  logic [7:0] rd_val [2];
  logic [1:0] pin_bit;
  for (genvar ch = 0; ch < 2; ch++) begin : g_ch
    ascc_chan #(
      .CH1 (ch == 1)
    ) u_chan (
      .clock    (clock),
      .reset_n  (reset_n),
      .io_write (io_write),
      .io_read  (io_read),
      .io_wdata (io_wdata),
      .sel_a    (io_addr == (ch ? ascc_pkg::ASCC_OFS_A1
                                : ascc_pkg::ASCC_OFS_A0)),
      .sel_b    (io_addr == (ch ? ascc_pkg::ASCC_OFS_B1
                                : ascc_pkg::ASCC_OFS_B0)),
      .sel_stat (io_addr == (ch ? ascc_pkg::ASCC_OFS_ST1
                                : ascc_pkg::ASCC_OFS_ST0)),
      .sel_tdr  (io_addr == (ch ? ascc_pkg::ASCC_OFS_TD1
                                : ascc_pkg::ASCC_OFS_TD0)),
      .sel_rdr  (io_addr == (ch ? ascc_pkg::ASCC_OFS_RD1
                                : ascc_pkg::ASCC_OFS_RD0)),
      .rd_value (rd_val[ch]),
      .halt     (peripheral_halt),
      .unity    (unity_clock_mode[ch]),
      .bgm      (baud_generator_mode[ch]),
      .ext_clk  (serial_clock_pin[ch]),
      .cts_n    (clear_to_send_n[ch]),
      .rxd      (rx_line[ch]),
      .txd      (tx_line[ch]),
      .bit4     (pin_bit[ch])
    );
  end
  assign request_to_send_out = pin_bit[0];
  assign clk_pin1_alt_select = pin_bit[1];
  // Unmapped addresses read as zero since no select is active.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      io_rdata <= 8'h00;
    end else if (io_read) begin
      io_rdata <= rd_val[0] | rd_val[1];
    end
  end
endmodule : ascc_top
`default_nettype wire

//--- test/ascc_link_model.sv
// Purpose: Far-end serial device that echoes every frame back.
// Assumes: One clock; both lines idle high.
// Notes:   The echo keeps frame shape, so receive sees what was sent.
`default_nettype none
module ascc_link_model (
  input  wire logic       clock,
  input  wire logic       reset_n,
  input  wire logic [1:0] tx_line,
  output logic      [1:0] rx_line
);
  timeunit 1ns;
  timeprecision 100ps;
  // One register stage stands for the far device's turn-around delay.
  // frame shape kept
  always_ff @(posedge clock) begin
    rx_line <= reset_n ? tx_line : 2'h3;
  end
endmodule : ascc_link_model
`default_nettype wire

//--- test/async_serial_channel_control_test.sv
// Purpose: Self-checking bench of the two serial channels.
// Assumes: Far end echoes each line back to its receiver.
// Notes:   Unity clock, prescale 0 and source 000 give a bit time of 10 clocks.
`default_nettype none
module async_serial_channel_control_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clock    = 1'b0;
  logic       reset_n  = 1'b0;
  logic [7:0] io_addr  = 8'h00;
  logic [7:0] io_wdata = 8'h00;
  logic       io_write = 1'b0;
  logic       io_read  = 1'b0;
  logic       halt     = 1'b0;
  logic [1:0] cts_n    = 2'h0;
  logic [1:0] sclk     = 2'h0;
  logic [1:0] ux       = 2'h3;
  logic [1:0] bg       = 2'h0;
  logic [7:0] io_rdata;
  logic [1:0] tx_line;
  logic [1:0] rx_line;
  logic       rts;
  logic       alt;
  logic [7:0] v;
  logic [7:0] d;
  logic [7:0] fmt;
  int         bad_count = 0;
  int         n_tests   = 0;
  int         cyc       = 0;
  int         k;
  // The clock and an external clock pin at one eighth its rate, toggling on clock falling edges.
  always #12.5 clock = ~clock;
  always #100 sclk = ~sclk;
  ascc_top dut_u (.clock(clock), .reset_n(reset_n), .io_addr(io_addr),
    .io_wdata(io_wdata), .io_write(io_write), .io_read(io_read),
    .io_rdata(io_rdata), .peripheral_halt(halt),
    .unity_clock_mode(ux), .baud_generator_mode(bg),
    .serial_clock_pin(sclk), .clear_to_send_n(cts_n), .rx_line(rx_line),
    .tx_line(tx_line), .request_to_send_out(rts),
    .clk_pin1_alt_select(alt));
  ascc_link_model far_u (.clock(clock), .reset_n(reset_n),
    .tx_line(tx_line), .rx_line(rx_line));
  // Register cycles: strobe set at a falling edge, held one full cycle.
  task automatic wr(input logic [7:0] a, input logic [7:0] w);
    @(negedge clock) {io_addr, io_wdata, io_write} = {a, w, 1'b1};
    @(negedge clock) io_write = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] r);
    @(negedge clock) {io_addr, io_read} = {a, 1'b1};
    @(negedge clock) io_read = 1'b0;
    @(negedge clock) r = io_rdata;
  endtask : rd
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // Seven-bit frames do not carry the top data bit, which reads as zero, so it is masked.
  function automatic logic [7:0] em(input logic [7:0] f);
    return f[2] ? 8'hff : 8'h7f;
  endfunction : em
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop
  // A hang is cut short well beyond the expected run length.
  always @(posedge clock) begin
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      report_and_stop();
    end
  end
  initial begin
    void'($urandom(88193));
    repeat (6) @(posedge clock);
    @(negedge clock) reset_n = 1'b1;
    rd(8'h02, v); chk(v, 8'h07);
    rd(8'h01, v); chk(v, 8'h00);
    chk({6'h00, alt, rts}, 8'h00);
    $display("test reset done");
    wr(8'h00, 8'h10); chk({6'h00, alt, rts}, 8'h01);
    wr(8'h01, 8'h10); chk({6'h00, alt, rts}, 8'h03);
    cts_n = 2'h1;
    rd(8'h02, v); chk(v, 8'h27);
    rd(8'h04, v); chk(v & 8'h02, 8'h00);
    cts_n = 2'h0;
    halt = 1'b1;
    wr(8'h00, 8'h60); rd(8'h00, v); chk(v & 8'h60, 8'h00);
    halt = 1'b0;
    rd(8'h3c, v); chk(v, 8'h00);
    $display("test registers done");
    for (int i = 0; i < 6; i++) begin
      fmt = (i == 0) ? 8'h07 : 8'($urandom_range(7));
      d = (i == 0) ? 8'hff : 8'($urandom);
      wr(8'h02, {2'h0, 2'($urandom), 4'h0});
      wr(8'h00, 8'h60 | fmt);
      wr(8'h06, d);
      v = 8'h00;
      k = 0;
      while (v[7] !== 1'b1 && k < 200) begin
        rd(8'h04, v);
        k++;
      end
      chk(v & 8'hf8, 8'h80);
      rd(8'h08, v); chk(v & em(fmt), d & em(fmt));
    end
    $display("test frames done");
    wr(8'h00, 8'he4);
    wr(8'h02, 8'h40); wr(8'h06, 8'h5a);
    repeat (200) @(negedge clock);
    rd(8'h04, v); chk(v & 8'h80, 8'h00);
    wr(8'h02, 8'hc0); wr(8'h06, 8'ha5);
    repeat (200) @(negedge clock);
    rd(8'h04, v); chk(v & 8'h80, 8'h80);
    rd(8'h00, v); chk(v & 8'h08, 8'h08);
    rd(8'h08, v); chk(v, 8'ha5);
    $display("test multiproc done");
    ux = 2'h2;
    d = 8'($urandom);
    wr(8'h02, 8'h00); wr(8'h00, 8'h64); wr(8'h06, d);
    repeat (2000) @(negedge clock);
    rd(8'h04, v); chk(v & 8'hf8, 8'h80);
    rd(8'h08, v); chk(v, d);
    ux = 2'h3;
    bg = 2'h1;
    wr(8'h02, 8'h20);
    bg = 2'h0;
    // Channel 0's shared pin is taken as set to its clock function.
    wr(8'h02, 8'h07); wr(8'h06, ~d);
    repeat (200) @(negedge clock);
    rd(8'h04, v); chk(v & 8'hf8, 8'h80);
    rd(8'h08, v); chk(v, ~d);
    $display("test clock modes done");
    wr(8'h02, 8'h00); wr(8'h00, 8'h64); wr(8'h06, 8'h00);
    repeat (20) @(negedge clock);
    wr(8'h00, 8'h44);
    @(negedge clock) chk({7'h00, tx_line[0]}, 8'h01);
    rd(8'h04, v); chk(v & 8'h02, 8'h02);
    $display("test abort done");
    report_and_stop();
  end
endmodule : async_serial_channel_control_test
`default_nettype wire
